//--- hdl/steh_pkg.sv
// How it works
// (RULE1) Rate conflict overflow sets formatter error flag
// (RULE2) Status byte shows scaler input field ID
// (RULE3) Status byte shows scaler output field ID
// (RULE4) Status read samples live state, no synchronisation
// (RULE5) Output field ID: input ID or toggling flag
// (RULE6) Polarity bit: bit 7 and flag 1/0
// (RULE7) Skip zero to seven fields before task
// (RULE8) Trigger: immediate, V-sync, field 0, field 1
// (RULE9) Repeat bit runs active task one extra time
// (RULE10) Request mode: on-demand source or continuous stream
// (RULE11) Two-bit select picks scaler input source
// (RULE12) Hold bit: F and V change at line start
// (RULE13) Vertical invert flips V bit and gate pin
// (RULE14) Sampling bit: 4:2:2-like or 4:1:1-like input
// (RULE15) Chroma every 1st-4th line, dummy bytes elsewhere
// (RULE16) Edge bit picks rising or falling vertical reference
// (RULE17) Frame-sync mode makes V pulses on both edges; the code does so only when the expansion port is the source
// (RULE18) Port field ID is horizontal ref at edge
// (RULE19) Field detect edge: falling at 0, rising 1
// (RULE20) Two independent register sets, A and B
// (RULE21) Event handler alternates between sets A and B
// (RULE22) Soft reset low idles the scaler path
// Constants, register layouts and states of the scaler task event handler.
// Assumes registers are reached by subaddress from the serial-bus slave outside.
package steh_pkg;
  localparam logic [7:0] ADDR_STATUS = 8'h8f;
  localparam logic [7:0] ADDR_TASK_A = 8'h90;
  localparam logic [7:0] ADDR_FMT_A  = 8'h91;
  localparam logic [7:0] ADDR_REF_A  = 8'h92;
  localparam logic [7:0] ADDR_TASK_B = 8'hc0;
  localparam logic [7:0] ADDR_FMT_B  = 8'hc1;
  localparam logic [7:0] ADDR_REF_B  = 8'hc2;
  localparam logic [7:0] RST_REG     = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam int         DATA_W      = 16;
  localparam int         FIFO_DEPTH  = 16;
  localparam logic [2:0] SKIP_MAX    = 3'h7;

  typedef enum logic [1:0] {
    TRIG_IMMEDIATE = 2'h0,
    TRIG_VSYNC     = 2'h1,
    TRIG_FIELD0    = 2'h2,
    TRIG_FIELD1    = 2'h3
  } steh_trig_t;

  // Gray order along idle -> wait -> skip -> run
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_SKIP = 2'b11,
    ST_RUN  = 2'b10
  } steh_state_t;

  typedef struct packed {
    logic       task_flag_polarity;
    logic       field_id_source_select;
    logic [2:0] field_skip_count;
    logic       task_repeat;
    steh_trig_t trigger_select;
  } steh_task_t;

  typedef struct packed {
    logic       vertical_invert;
    logic       ref_code_hold;
    logic [1:0] scaler_source_select;
    logic       request_mode;
    logic [1:0] chroma_line_interval;
    logic       input_sampling_scheme;
  } steh_fmt_t;

  typedef struct packed {
    logic       field_detect_edge;
    logic       field_id_invert;
    logic       frame_sync_mode;
    logic       vertical_edge_select;
    logic [3:0] other_ref_bits;
  } steh_ref_t;
endpackage

//--- hdl/steh_edge_det.sv
// Edge detector giving one-cycle rise and fall pulses.
// Assumes the input is already synchronous to clk_i.
`timescale 1ns/100ps
module steh_edge_det (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic sig_i,
  output logic      rise_o,
  output logic      fall_o
);
  logic prev_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= sig_i;
    end
  end

  assign rise_o = sig_i & ~prev_q;
  assign fall_o = ~sig_i & prev_q;
endmodule

//--- hdl/steh_fifo.sv
// Input sample FIFO between the scaler input source and the scaler core.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/100ps
module steh_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             flush_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic                  almost_full_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, rd_q;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  assign push = in_valid_i & in_ready_o;
  assign pop  = out_valid_o & out_ready_i;
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_q          <= '0;
      rd_q          <= '0;
      cnt_q         <= '0;
      in_ready_o    <= 1'b1;
      out_valid_o   <= 1'b0;
      almost_full_o <= 1'b0;
    end else if (flush_i) begin
      wr_q          <= '0;
      rd_q          <= '0;
      cnt_q         <= '0;
      in_ready_o    <= 1'b1;
      out_valid_o   <= 1'b0;
      almost_full_o <= 1'b0;
    end else begin
      if (push) wr_q <= wr_q + AW'(1);
      if (pop) rd_q <= rd_q + AW'(1);
      cnt_q         <= cnt_d;
      in_ready_o    <= cnt_d != (AW+1)'(DEPTH);
      out_valid_o   <= cnt_d != '0;
      almost_full_o <= cnt_d >= (AW+1)'(DEPTH-1);
    end
  end

  assign out_data_o = mem_q[rd_q];
endmodule

//--- hdl/steh_top.sv
// Scaler task event handler: register sets A/B, status byte, event
// handler, reference signal decoding and the input sample FIFO.
// Assumes all inputs are synchronous to clk_i and register accesses
// arrive as subaddress strobes from the serial-bus slave outside.
`timescale 1ns/100ps
module steh_top (
  input  wire logic                       clk_i,
  input  wire logic                       rst_b_i,
  // Subaddress register access
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  input  wire logic [7:0]                 reg_addr_i,
  input  wire logic [7:0]                 reg_wdata_i,
  output logic [7:0]                      reg_rdata_o,
  // Global controls held elsewhere
  input  wire logic                       scaler_soft_reset_i,
  input  wire logic                       port_request_enable_i,
  // Reference signals
  input  wire logic                       ext_vertical_ref_i,
  input  wire logic                       ext_horizontal_ref_i,
  input  wire logic                       decoder_vertical_signal_i,
  input  wire logic                       decoder_field_id_i,
  input  wire logic                       vertical_gate_int_i,
  input  wire logic                       line_start_i,
  input  wire logic                       task_done_i,
  // Sample stream
  input  wire logic [steh_pkg::DATA_W-1:0] in_data_i,
  input  wire logic                       in_valid_i,
  output logic                            in_ready_o,
  output logic [steh_pkg::DATA_W-1:0]     out_data_o,
  output logic                            out_valid_o,
  input  wire logic                       out_ready_i,
  // Results
  output steh_pkg::steh_fmt_t             active_fmt_o,
  output logic                            task_active_o,
  output logic                            task_flag_o,
  output logic                            ref_f_o,
  output logic                            ref_v_o,
  output logic                            ref_bit7_o,
  output logic                            output_vertical_gate_pin_o
);
  // ------------------------------------------------------------------
  // Register sets
  // ------------------------------------------------------------------
  steh_pkg::steh_task_t task_a_q, task_b_q, cur_task;
  steh_pkg::steh_fmt_t  fmt_a_q, fmt_b_q, cur_fmt;
  steh_pkg::steh_ref_t  ref_a_q, ref_b_q, cur_ref;
  logic                 set_b_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      task_a_q <= steh_pkg::RST_REG;
      fmt_a_q  <= steh_pkg::RST_REG;
      ref_a_q  <= steh_pkg::RST_REG;
      task_b_q <= steh_pkg::RST_REG;
      fmt_b_q  <= steh_pkg::RST_REG;
      ref_b_q  <= steh_pkg::RST_REG;
    end else if (reg_wr_i) begin
      if (reg_addr_i == steh_pkg::ADDR_TASK_A) begin // RULE20
        task_a_q <= reg_wdata_i;
      end else if (reg_addr_i == steh_pkg::ADDR_FMT_A) begin
        fmt_a_q <= reg_wdata_i;
      end else if (reg_addr_i == steh_pkg::ADDR_REF_A) begin
        ref_a_q <= reg_wdata_i;
      end else if (reg_addr_i == steh_pkg::ADDR_TASK_B) begin
        task_b_q <= reg_wdata_i;
      end else if (reg_addr_i == steh_pkg::ADDR_FMT_B) begin
        fmt_b_q <= reg_wdata_i;
      end else if (reg_addr_i == steh_pkg::ADDR_REF_B) begin
        ref_b_q <= reg_wdata_i;
      end
    end
  end

  // Parameters of whichever set is active
  assign cur_task = set_b_q ? task_b_q : task_a_q; // RULE21
  assign cur_fmt  = set_b_q ? fmt_b_q : fmt_a_q;
  assign cur_ref  = set_b_q ? ref_b_q : ref_a_q;

  // ------------------------------------------------------------------
  // Vertical reference and field ID
  // ------------------------------------------------------------------
  logic dec_rise, dec_fall, ext_rise, ext_fall;
  logic src_ext, v_rise, v_fall, vpulse;
  logic xfid_q, in_fid, fid_edge;

  steh_edge_det u_dec_edge (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .sig_i   (decoder_vertical_signal_i),
    .rise_o  (dec_rise),
    .fall_o  (dec_fall)
  );

  steh_edge_det u_ext_edge (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .sig_i   (ext_vertical_ref_i),
    .rise_o  (ext_rise),
    .fall_o  (ext_fall)
  );

  // Sources 01 and 11 come from the expansion port
  assign src_ext = cur_fmt.scaler_source_select[0]; // RULE11
  assign v_rise  = src_ext ? ext_rise : dec_rise;
  assign v_fall  = src_ext ? ext_fall : dec_fall;
  assign vpulse  = (src_ext && cur_ref.frame_sync_mode) ? (v_rise | v_fall) : // RULE17
                   (cur_ref.vertical_edge_select ? v_fall : v_rise); // RULE16
  assign fid_edge = cur_ref.field_detect_edge ? ext_rise : ext_fall; // RULE19

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      xfid_q <= 1'b0;
    end else if (fid_edge) begin
      xfid_q <= ext_horizontal_ref_i; // RULE18
    end
  end

  assign in_fid = (src_ext ? xfid_q : decoder_field_id_i) ^ cur_ref.field_id_invert; // RULE18

  // ------------------------------------------------------------------
  // Event handler
  // ------------------------------------------------------------------
  steh_pkg::steh_state_t state_q;
  logic [2:0]            skip_q;
  logic                  rep_q, trig_hit, task_flag_q, finish;

  always_comb begin
    case (cur_task.trigger_select) // RULE8
      steh_pkg::TRIG_IMMEDIATE: trig_hit = 1'b1;
      steh_pkg::TRIG_VSYNC:     trig_hit = vpulse;
      steh_pkg::TRIG_FIELD0:    trig_hit = vpulse & ~in_fid;
      default:                  trig_hit = vpulse & in_fid;
    endcase
  end

  assign finish = (state_q == steh_pkg::ST_RUN) && task_done_i;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= steh_pkg::ST_IDLE;
      skip_q  <= '0;
    end else if (!scaler_soft_reset_i) begin
      state_q <= steh_pkg::ST_IDLE; // RULE22
      skip_q  <= '0;
    end else begin
      case (state_q)
        steh_pkg::ST_IDLE: begin
          state_q <= steh_pkg::ST_WAIT;
        end
        steh_pkg::ST_WAIT: begin
          if (trig_hit) begin
            skip_q <= cur_task.field_skip_count;
            // Zero skip runs the task directly
            state_q <= (cur_task.field_skip_count == '0) ? steh_pkg::ST_RUN
                                                          : steh_pkg::ST_SKIP; // RULE7
          end
        end
        steh_pkg::ST_SKIP: begin
          if (vpulse) begin
            skip_q <= skip_q - 3'h1;
            if (skip_q == 3'h1) begin
              state_q <= steh_pkg::ST_RUN; // RULE7
            end
          end
        end
        default: begin
          if (task_done_i) begin
            state_q <= steh_pkg::ST_WAIT;
          end
        end
      endcase
    end
  end

  // Set alternation and single repeat
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      set_b_q <= 1'b0;
      rep_q   <= 1'b0;
    end else if (!scaler_soft_reset_i) begin
      set_b_q <= 1'b0;
      rep_q   <= 1'b0;
    end else if (finish) begin
      if (cur_task.task_repeat && !rep_q) begin
        rep_q <= 1'b1; // RULE9
      end else begin
        rep_q   <= 1'b0;
        set_b_q <= ~set_b_q; // RULE21
      end
    end
  end

  // Flag toggles on every task activation, independent of input fields
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      task_flag_q <= 1'b0;
    end else if (state_q != steh_pkg::ST_RUN &&
                 ((state_q == steh_pkg::ST_WAIT && trig_hit &&
                   cur_task.field_skip_count == '0) ||
                  (state_q == steh_pkg::ST_SKIP && vpulse && skip_q == 3'h1))) begin
      task_flag_q <= ~task_flag_q; // RULE5
    end
  end

  // ------------------------------------------------------------------
  // Output field ID and timing reference bits
  // ------------------------------------------------------------------
  logic out_fid_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_fid_q                  <= 1'b0;
      ref_f_o                    <= 1'b0;
      ref_v_o                    <= 1'b0;
      ref_bit7_o                 <= 1'b1;
      task_flag_o                <= 1'b1;
      output_vertical_gate_pin_o <= 1'b0;
      task_active_o              <= 1'b0;
      active_fmt_o               <= steh_pkg::RST_REG;
    end else begin
      out_fid_q <= cur_task.field_id_source_select ? task_flag_q : in_fid; // RULE5
      // Polarity maps flag 1 to 0 when clear
      ref_bit7_o  <= task_flag_q ^ cur_task.task_flag_polarity ^ 1'b1; // RULE6
      task_flag_o <= task_flag_q ^ cur_task.task_flag_polarity ^ 1'b1; // RULE6
      if (!cur_fmt.ref_code_hold || line_start_i) begin // RULE12
        ref_f_o <= out_fid_q;
        ref_v_o <= vertical_gate_int_i ^ cur_fmt.vertical_invert; // RULE13
      end
      output_vertical_gate_pin_o <= vertical_gate_int_i ^ cur_fmt.vertical_invert; // RULE13
      task_active_o <= (state_q == steh_pkg::ST_RUN);
      // Source, sampling and chroma-line settings go to the scaler core
      active_fmt_o <= cur_fmt; // RULE11 RULE14 RULE15
    end
  end

  // ------------------------------------------------------------------
  // Sample FIFO and rate conflict detection
  // ------------------------------------------------------------------
  logic fifo_ready, fifo_afull, req_q, drop, err_q;

  // A continuous stream cannot be stalled, so a full FIFO drops data
  steh_fifo #(
    .WIDTH (steh_pkg::DATA_W),
    .DEPTH (steh_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i         (clk_i),
    .rst_b_i       (rst_b_i),
    .flush_i       (~scaler_soft_reset_i),
    .in_data_i     (in_data_i),
    .in_valid_i    (in_valid_i & req_q),
    .in_ready_o    (fifo_ready),
    .almost_full_o (fifo_afull),
    .out_data_o    (out_data_o),
    .out_valid_o   (out_valid_o),
    .out_ready_i   (out_ready_i)
  );

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_q <= 1'b0;
    end else if (!scaler_soft_reset_i) begin
      req_q <= 1'b0;
    end else if (cur_fmt.request_mode || !port_request_enable_i) begin
      req_q <= 1'b1; // RULE10
    end else begin
      req_q <= ~fifo_afull; // RULE10
    end
  end

  assign in_ready_o = req_q;
  assign drop = in_valid_i & req_q & ~fifo_ready;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      err_q <= 1'b0;
    end else if (drop) begin
      err_q <= 1'b1; // RULE1
    end else if (!scaler_soft_reset_i) begin
      err_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Register read
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= steh_pkg::RD_UNMAPPED;
    end else if (reg_rd_i) begin
      if (reg_addr_i == steh_pkg::ADDR_STATUS) begin
        reg_rdata_o <= {5'h00, err_q, in_fid, out_fid_q}; // RULE2 RULE3 RULE4
      end else if (reg_addr_i == steh_pkg::ADDR_TASK_A) begin
        reg_rdata_o <= task_a_q;
      end else if (reg_addr_i == steh_pkg::ADDR_FMT_A) begin
        reg_rdata_o <= fmt_a_q;
      end else if (reg_addr_i == steh_pkg::ADDR_REF_A) begin
        reg_rdata_o <= ref_a_q;
      end else if (reg_addr_i == steh_pkg::ADDR_TASK_B) begin
        reg_rdata_o <= task_b_q;
      end else if (reg_addr_i == steh_pkg::ADDR_FMT_B) begin
        reg_rdata_o <= fmt_b_q;
      end else if (reg_addr_i == steh_pkg::ADDR_REF_B) begin
        reg_rdata_o <= ref_b_q;
      end else begin
        reg_rdata_o <= steh_pkg::RD_UNMAPPED;
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_err_on_drop: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE1
    drop |=> err_q ##1 (err_q || !$past(scaler_soft_reset_i)))
    else $error("drop did not set error flag");

  a_status_fids: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE2
    (reg_rd_i && reg_addr_i == steh_pkg::ADDR_STATUS) |=>
      reg_rdata_o[1:0] == {$past(in_fid), $past(out_fid_q)})
    else $error("status byte field IDs wrong");

  a_out_fid_src: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE5
    !cur_task.field_id_source_select |=> out_fid_q == $past(in_fid))
    else $error("output field ID not following input");

  a_flag_polarity: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE6
    ##1 ref_bit7_o == ($past(task_flag_q) ^ ~$past(cur_task.task_flag_polarity)))
    else $error("bit 7 polarity wrong");

  a_direct_run: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE8
    (scaler_soft_reset_i && state_q == steh_pkg::ST_WAIT &&
     cur_task.trigger_select == steh_pkg::TRIG_IMMEDIATE &&
     cur_task.field_skip_count == 3'h0) |=> state_q == steh_pkg::ST_RUN ##1 task_active_o)
    else $error("immediate trigger did not run task");

  a_repeat_once: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE9
    (scaler_soft_reset_i && finish && cur_task.task_repeat && !rep_q) |=>
      set_b_q == $past(set_b_q) && rep_q)
    else $error("repeat did not keep the set");

  a_set_alternate: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE21
    (scaler_soft_reset_i && finish && (!cur_task.task_repeat || rep_q)) |=>
      set_b_q != $past(set_b_q))
    else $error("set did not alternate");

  a_vgate_invert: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE13
    ##1 output_vertical_gate_pin_o ==
        ($past(vertical_gate_int_i) ^ $past(cur_fmt.vertical_invert)))
    else $error("vertical gate inversion wrong");

  a_hold_ref: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE12
    (cur_fmt.ref_code_hold && !line_start_i) |=> $stable(ref_f_o) && $stable(ref_v_o))
    else $error("reference bits changed off line start");

  a_soft_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE22
    !scaler_soft_reset_i |=> state_q == steh_pkg::ST_IDLE && !out_valid_o)
    else $error("soft reset did not idle scaler");
endmodule

//--- tb/steh_src_model.sv
// Video source model feeding the scaler input stream with counting words.
// Assumes the bench enables it and the design answers with in_ready_o.
`timescale 1ns/100ps
module steh_src_model (
  input  wire logic                        clk_i,
  input  wire logic                        rst_b_i,
  input  wire logic                        en_i,
  input  wire logic                        ready_i,
  output logic [steh_pkg::DATA_W-1:0]      data_o,
  output logic                             valid_o
);
  logic [steh_pkg::DATA_W-1:0] cnt_q;
  // Word held until taken; a released bus toggles each cycle between its last word and that word's inverse
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q   <= 16'h0000;
      valid_o <= 1'b0;
      data_o  <= 16'hffff;
    end else if (!valid_o || ready_i) begin
      cnt_q   <= cnt_q + 16'(valid_o);
      valid_o <= en_i;
      data_o  <= en_i ? cnt_q + 16'(valid_o) : ~data_o;
    end
  end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the scaler task event handler.
// Assumes steh_top, the source model and one 100 MHz clock.
`timescale 1ns/100ps
module testbench;
  logic                clk_i, rst_b_i, wr, rd, srst, preq, dv, fid, vg, done, oready, src_en;
  logic                xv, xh, ls;
  logic [7:0]          addr, wdata, rdata, st;
  logic [15:0]         idata, odata;
  logic                ivalid, iready, ovalid, act, flag, f, v, b7, gate;
  steh_pkg::steh_fmt_t fmt;
  int                  n_mismatch, n_compared, n_in, n_cyc;

  steh_top dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .scaler_soft_reset_i(srst), .port_request_enable_i(preq),
    .ext_vertical_ref_i(xv), .ext_horizontal_ref_i(xh),
    .decoder_vertical_signal_i(dv), .decoder_field_id_i(fid), .vertical_gate_int_i(vg),
    .line_start_i(ls), .task_done_i(done), .in_data_i(idata), .in_valid_i(ivalid),
    .in_ready_o(iready), .out_data_o(odata), .out_valid_o(ovalid), .out_ready_i(oready),
    .active_fmt_o(fmt), .task_active_o(act), .task_flag_o(flag), .ref_f_o(f),
    .ref_v_o(v), .ref_bit7_o(b7), .output_vertical_gate_pin_o(gate));
  steh_src_model src_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(src_en),
    .ready_i(iready), .data_o(idata), .valid_o(ivalid));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk_i) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i) begin addr <= a; rd <= 1'b1; end
    @(posedge clk_i) rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Bounded wait; the pass that never reaches the level is caught by chk
  task automatic wait_act(input logic lvl);
    for (int k = 0; k < 20 && act !== lvl; k++) @(posedge clk_i) #1;
    chk(16'(act), 16'(lvl));
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic vpulse();
    @(posedge clk_i) {dv, xv} <= 2'b11;
    repeat (4) @(posedge clk_i);
    {dv, xv} <= 2'b00;
    repeat (8) @(posedge clk_i);
    #1;
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] a [6] = '{8'h90, 8'h91, 8'h92, 8'hc0, 8'hc1, 8'hc2};
    for (int i = 0; i < 6; i++) begin
      rd_reg(a[i], st);
      chk(16'(st), 16'h0000);
      wr_reg(a[i], 8'(8'h31 + i));
    end
    wr_reg(8'h8f, 8'hff);
    for (int i = 0; i < 6; i++) begin
      rd_reg(a[i], st);
      chk(16'(st), 16'(8'h31 + i));
    end
    rd_reg(8'h93, st);
    chk(16'(st), 16'h0000);
    rd_reg(8'h8f, st);
    chk(16'(st & 8'hf8), 16'h0000);
    $display("test registers done");
  endtask
  // Set A repeats once, then B with inverted flag polarity takes over
  task automatic t_task();
    logic [7:0] ef [3] = '{8'h08, 8'h08, 8'h18};
    logic       eg [3] = '{1'b0, 1'b1, 1'b1};
    wr_reg(8'h90, 8'h04);
    wr_reg(8'hc0, 8'h80);
    wr_reg(8'h91, 8'h08);
    wr_reg(8'hc1, 8'h18);
    @(posedge clk_i) srst <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wait_act(1'b1);
      chk(16'(fmt), 16'(ef[i]));
      chk(16'(flag), 16'(eg[i]));
      chk(16'(b7), 16'(eg[i]));
      @(posedge clk_i) done <= 1'b1;
      @(posedge clk_i) done <= 1'b0;
      wait_act(1'b0);
    end
    @(posedge clk_i) srst <= 1'b0;
    $display("test task sequencing done");
  endtask
  task automatic t_skip();
    wr_reg(8'h90, 8'h11);
    wr_reg(8'h91, 8'h88);
    wr_reg(8'h92, 8'h00);
    @(posedge clk_i) begin srst <= 1'b1; fid <= 1'b1; vg <= 1'b1; end
    for (int i = 1; i <= 3; i++) begin
      vpulse();
      chk(16'(act), 16'(i == 3));
    end
    rd_reg(8'h8f, st);
    chk(16'(st & 8'h03), 16'h0003);
    chk(16'(gate), 16'h0000);
    chk(16'({f, v}), 16'h0002);
    // Hold set: V bit waits for a line start while the gate pin follows at once
    wr_reg(8'h91, 8'hc8);
    @(posedge clk_i) vg <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1 chk(16'({gate, v}), 16'h0002);
    @(posedge clk_i) ls <= 1'b1;
    @(posedge clk_i) ls <= 1'b0;
    #1 chk(16'(v), 16'h0001);
    @(posedge clk_i) begin srst <= 1'b0; fid <= 1'b0; vg <= 1'b0; end
    $display("test field skip done");
  endtask
  // Field ID latched from the horizontal ref at the falling V edge, used at the next rise
  task automatic t_xport();
    wr_reg(8'h90, 8'h03);
    wr_reg(8'h91, 8'h18);
    wr_reg(8'h92, 8'h00);
    @(posedge clk_i) begin srst <= 1'b1; xh <= 1'b1; end
    for (int i = 0; i < 2; i++) begin
      vpulse();
      chk(16'(act), 16'(i));
    end
    rd_reg(8'h8f, st);
    chk(16'(st & 8'h02), 16'h0002);
    @(posedge clk_i) begin srst <= 1'b0; xh <= 1'b0; end
    $display("test expansion port done");
  endtask
  task automatic t_fifo();
    int n_out;
    n_out = 0;
    wr_reg(8'h91, 8'h10);
    n_in = 0;
    @(posedge clk_i) begin srst <= 1'b1; preq <= 1'b1; src_en <= 1'b1; end
    repeat (40) @(posedge clk_i);
    #1;
    chk(16'(n_in), 16'h0010);
    chk(16'(iready), 16'h0000);
    @(posedge clk_i) begin src_en <= 1'b0; oready <= 1'b1; end
    repeat (40) begin
      #1;
      if (ovalid && oready) begin
        chk(odata, 16'(n_out));
        n_out++;
      end
      @(posedge clk_i);
    end
    // Sixteen buffered words, then the word the source held while refused
    chk(16'(n_out), 16'h0011);
    // Continuous mode with a stalled sink must overflow and flag it
    @(posedge clk_i) begin srst <= 1'b0; oready <= 1'b0; end
    wr_reg(8'h91, 8'h08);
    @(posedge clk_i) begin srst <= 1'b1; src_en <= 1'b1; end
    repeat (30) @(posedge clk_i);
    rd_reg(8'h8f, st);
    chk(16'(st & 8'h04), 16'h0004);
    @(posedge clk_i) begin srst <= 1'b0; src_en <= 1'b0; end
    repeat (2) @(posedge clk_i);
    rd_reg(8'h8f, st);
    chk(16'(st & 8'h04), 16'h0000);
    $display("test stream buffer done");
  endtask

  // ------------------------------------------------------------
  // Clock, reset, timeout and main sequence
  // ------------------------------------------------------------
  always @(posedge clk_i) if (ivalid && iready) n_in++;
  always @(posedge clk_i) begin
    n_cyc++;
    if (n_cyc == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    {rst_b_i, wr, rd, srst, preq, dv, fid, vg, done, oready, src_en, xv, xh, ls} = '0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_task();
    t_skip();
    t_xport();
    t_fifo();
    finish_test();
  end
endmodule
